// file: hpsfc_top.sv
// host-facing pins: activity and carrier indicators, flow control, general pins
`include "hpsfc_map.svh"
// Contract
// (RULE_01) base: activity blinks on each valid received packet
// (RULE_02) remote: activity blinks on each transmitted packet
// (RULE_03) router: blinks on valid upstream receive or downstream transmit
// (RULE_04) base: carrier detect asserts on valid packet, clears after registration timeout
// (RULE_05) router/remote: carrier asserts on sync, clears after 50 beaconless hops
// (RULE_06) activity pin may instead carry diagnostic serial output
// (RULE_07) carrier pin may instead carry diagnostic serial input
// (RULE_08) flow control: clear-to-send low while data can be accepted
// (RULE_09) host stops sending while clear-to-send is high
// (RULE_10) host drives request-to-send low to permit module transmit
// (RULE_11) module stops transmitting while request-to-send is high
// (RULE_12) input pins offer pull-up and wake-from-sleep interrupt
// (RULE_13) output pin takes configurable power-on level
// (RULE_14) sleep uses separate direction, pull-up and output level
// (RULE_15) pins 1 and 2 have the same options as pin 0
// (RULE_16) pins 4 and 5 as pin 2, or flow-control pins
// (RULE_17) after reset each muxed pin takes its default function
module hpsfc_top #(
    parameter int unsigned BLINK_CYCLES = `HPSFC_BLINK_CYC,
    parameter int unsigned REG_TO_W     = 32,
    parameter int unsigned NUM_GPIO     = 6
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      clk_en,
    input  wire hpsfc_pkg::hpsfc_role_t    role,
    input  wire hpsfc_pkg::hpsfc_radio_ev_t radio_ev,
    input  wire logic [REG_TO_W-1:0]       reg_timeout_cycles,
    input  wire logic                      diag_alt_en,
    input  wire logic                      diag_serial_out,
    output logic                           diag_serial_in,
    input  wire logic                      flow_ctrl_en,
    input  wire logic                      rx_can_accept,
    output logic                           tx_permit,
    input  wire logic                      sleeping,
    input  wire hpsfc_pkg::hpsfc_pin_cfg_t awake_cfg [NUM_GPIO],
    input  wire hpsfc_pkg::hpsfc_pin_cfg_t sleep_cfg [NUM_GPIO],
    output logic                           activity_indicator,
    input  wire logic                      carrier_detect_n_in,
    output logic                           carrier_detect_n,
    output logic                           carrier_detect_oe_n,
    input  wire logic [NUM_GPIO-1:0]       gpio_in,
    output logic [NUM_GPIO-1:0]            gpio_out,
    output logic [NUM_GPIO-1:0]            gpio_oe_n,
    output logic [NUM_GPIO-1:0]            gpio_pull_up,
    output logic [NUM_GPIO-1:0]            gpio_level,
    output logic                           wake_irq
);
    import hpsfc_pkg::*;

    // refuse shapes that the fixed pin map and the 32-bit counters cannot serve
    if (NUM_GPIO != 6 || BLINK_CYCLES < 1 || REG_TO_W < 1 || REG_TO_W > 32) begin : g_bad_param
        $error("hpsfc_top: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // activity blink
    // ----------------------------------------------------------------
    logic        act_event;
    logic [31:0] blink_reg, blink_next;

    // which radio event counts depends on the node role
    always_comb begin
        case (role)
            HPSFC_ROLE_BASE:   act_event = radio_ev.rx_valid; // RULE_01
            HPSFC_ROLE_REMOTE: act_event = radio_ev.tx_packet; // RULE_02
            HPSFC_ROLE_ROUTER: act_event = radio_ev.rx_upstream | radio_ev.tx_downstream; // RULE_03
            default:           act_event = 1'b0;
        endcase
    end

    // a new event restarts the blink so bursts read as one long flash
    always_comb begin
        blink_next = blink_reg;
        if (clk_en) begin
            if (act_event)
                blink_next = 32'(BLINK_CYCLES);
            else if (blink_reg != 32'h0)
                blink_next = blink_reg - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n)
            blink_reg <= 32'h0;
        else
            blink_reg <= blink_next;
    end

    // ----------------------------------------------------------------
    // carrier detect
    // ----------------------------------------------------------------
    logic                cd_reg, cd_next;
    logic [REG_TO_W-1:0] quiet_reg, quiet_next;
    logic [5:0]          hops_reg, hops_next;

    // base times out in clock cycles, others count beaconless hops
    always_comb begin
        cd_next    = cd_reg;
        quiet_next = quiet_reg;
        hops_next  = hops_reg;
        if (clk_en) begin
            if (role == HPSFC_ROLE_BASE) begin
                hops_next = 6'h0;
                if (radio_ev.rx_valid) begin
                    cd_next    = 1'b1; // RULE_04
                    quiet_next = '0;
                end else if (cd_reg) begin
                    if (quiet_reg >= reg_timeout_cycles)
                        cd_next = 1'b0; // RULE_04
                    else
                        quiet_next = quiet_reg + 1'b1;
                end
            end else begin
                quiet_next = '0;
                if (radio_ev.sync_gained || radio_ev.beacon_heard) begin
                    if (radio_ev.sync_gained)
                        cd_next = 1'b1; // RULE_05
                    hops_next = 6'h0;
                end else if (cd_reg && radio_ev.hop_tick) begin
                    if (hops_reg == 6'(`HPSFC_LOST_HOPS - 1)) begin
                        cd_next   = 1'b0; // RULE_05
                        hops_next = 6'h0;
                    end else
                        hops_next = hops_reg + 6'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cd_reg    <= 1'b0;
            quiet_reg <= '0;
            hops_reg  <= 6'h0;
        end else begin
            cd_reg    <= cd_next;
            quiet_reg <= quiet_next;
            hops_reg  <= hops_next;
        end
    end

    // ----------------------------------------------------------------
    // diagnostic port pins and sync
    // ----------------------------------------------------------------
    logic diag_s1_reg, diag_s1_next, diag_s2_reg, diag_s2_next;
    logic act_reg, act_next;

    // the diag input is a pin, so it passes two flops first
    always_comb begin
        diag_s1_next = diag_s1_reg;
        diag_s2_next = diag_s2_reg;
        act_next     = act_reg;
        if (clk_en) begin
            diag_s1_next = carrier_detect_n_in;
            diag_s2_next = diag_s1_reg;
            act_next     = diag_alt_en ? diag_serial_out : (blink_next != 32'h0); // RULE_06 RULE_17
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            diag_s1_reg <= 1'b1;
            diag_s2_reg <= 1'b1;
            act_reg     <= 1'b0;
        end else begin
            diag_s1_reg <= diag_s1_next;
            diag_s2_reg <= diag_s2_next;
            act_reg     <= act_next;
        end
    end

    assign activity_indicator  = act_reg;
    assign carrier_detect_n    = ~cd_reg;
    assign carrier_detect_oe_n = diag_alt_en; // RULE_07 RULE_17
    assign diag_serial_in      = diag_alt_en ? diag_s2_reg : 1'b1; // RULE_07

    // ----------------------------------------------------------------
    // general pins and flow control
    // ----------------------------------------------------------------
    logic [NUM_GPIO-1:0] cell_out, cell_oe_n, cell_pu, cell_wake;
    logic                cts_reg, cts_next;

    // every pin gets the same cell, so pins 1,2,4,5 match pin 0
    for (genvar i = 0; i < NUM_GPIO; i++) begin : g_pin
        hpsfc_gpio_cell u_cell ( // RULE_15
            .clk        (clk),
            .reset_n    (reset_n),
            .clk_en     (clk_en),
            .awake_cfg  (awake_cfg[i]),
            .sleep_cfg  (sleep_cfg[i]),
            .sleeping   (sleeping),
            .pin_in     (gpio_in[i]),
            .pin_out    (cell_out[i]),
            .pin_oe_n   (cell_oe_n[i]),
            .pull_up_en (cell_pu[i]),
            .wake_req   (cell_wake[i]),
            .pin_level  (gpio_level[i])
        );
    end

    // clear-to-send is registered so the pin never glitches
    always_comb begin
        cts_next = cts_reg;
        if (clk_en)
            cts_next = ~rx_can_accept; // RULE_08
    end

    always_ff @(posedge clk) begin
        if (!reset_n)
            cts_reg <= 1'b1;
        else
            cts_reg <= cts_next;
    end

    // pins 4 and 5 turn into flow control only while it is enabled
    always_comb begin
        gpio_out     = cell_out;
        gpio_oe_n    = cell_oe_n;
        gpio_pull_up = cell_pu;
        if (flow_ctrl_en) begin
            gpio_out[4]     = cts_reg; // RULE_16 RULE_08
            gpio_oe_n[4]    = 1'b0;
            gpio_pull_up[4] = 1'b0;
            gpio_out[5]     = 1'b0;
            gpio_oe_n[5]    = 1'b1;
            gpio_pull_up[5] = 1'b1; // RULE_16
        end
    end

    // rts high withholds transmit; the flow-control flag gates it
    assign tx_permit = ~flow_ctrl_en | ~gpio_level[5]; // RULE_11 RULE_10
    // pins 4 and 5 lose their wake only while they serve flow control
    assign wake_irq  = |(cell_wake & {{2{~flow_ctrl_en}}, 4'b1111}); // RULE_12
endmodule // hpsfc_top

// file: hpsfc_map.svh
// timing counts and reset values for the host pin status and flow control block
`ifndef HPSFC_MAP_SVH
`define HPSFC_MAP_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPSFC_BLINK_NS        50000000
`define HPSFC_CLK_NS          5
`define HPSFC_BLINK_CYC       (`HPSFC_BLINK_NS / `HPSFC_CLK_NS)
`define HPSFC_LOST_HOPS       50
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HPSFC_GPIO_RST_DIR    1'b0
`define HPSFC_GPIO_RST_OUT    1'b0
`endif

// file: hpsfc_pkg.sv
// types shared by the host pin status and flow control block
package hpsfc_pkg;
    typedef enum logic [2:0] {
        HPSFC_ROLE_BASE   = 3'b001,
        HPSFC_ROLE_ROUTER = 3'b010,
        HPSFC_ROLE_REMOTE = 3'b100
    } hpsfc_role_t;

    // one general pin's configuration, awake or asleep
    typedef struct packed {
        logic dir_out;
        logic pull_up;
        logic wake_en;
        logic out_level;
    } hpsfc_pin_cfg_t;

    // radio events, one-cycle pulses
    typedef struct packed {
        logic rx_valid;
        logic rx_upstream;
        logic tx_packet;
        logic tx_downstream;
        logic sync_gained;
        logic hop_tick;
        logic beacon_heard;
    } hpsfc_radio_ev_t;
endpackage

// file: hpsfc_gpio_cell.sv
// one configurable general pin: direction, pull-up, wake, power-on and sleep state
`include "hpsfc_map.svh"
module hpsfc_gpio_cell (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    input  wire hpsfc_pkg::hpsfc_pin_cfg_t awake_cfg,
    input  wire hpsfc_pkg::hpsfc_pin_cfg_t sleep_cfg,
    input  wire logic                     sleeping,
    input  wire logic                     pin_in,
    output logic                          pin_out,
    output logic                          pin_oe_n,
    output logic                          pull_up_en,
    output logic                          wake_req,
    output logic                          pin_level
);
    import hpsfc_pkg::*;
    hpsfc_pin_cfg_t cfg;
    logic sync1_reg, sync1_next, sync2_reg, sync2_next;
    logic dir_reg, dir_next, out_reg, out_next, pu_reg, pu_next;

    // pick the live set; sleep has its own independent settings
    assign cfg = sleeping ? sleep_cfg : awake_cfg; // RULE_14

    always_comb begin
        sync1_next = sync1_reg;
        sync2_next = sync2_reg;
        dir_next   = dir_reg;
        out_next   = out_reg;
        pu_next    = pu_reg;
        if (clk_en) begin
            sync1_next = pin_in;
            sync2_next = sync1_reg;
            dir_next   = cfg.dir_out;
            out_next   = cfg.out_level; // RULE_13
            pu_next    = cfg.pull_up & ~cfg.dir_out; // RULE_12
        end
    end

    // reset parks the pin as an input until the configuration arrives
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            dir_reg   <= `HPSFC_GPIO_RST_DIR;
            out_reg   <= `HPSFC_GPIO_RST_OUT;
            pu_reg    <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            dir_reg   <= dir_next;
            out_reg   <= out_next;
            pu_reg    <= pu_next;
        end
    end

    assign pin_out    = out_reg;
    assign pin_oe_n   = ~dir_reg;
    assign pull_up_en = pu_reg;
    assign pin_level  = sync2_reg;
    // wake only from an input pin pulled low; level, so it holds across sleep
    assign wake_req   = sleeping & cfg.wake_en & ~cfg.dir_out & ~sync2_reg; // RULE_12
endmodule // hpsfc_gpio_cell

// file: hpsfc_monitor.sv
// assertion checker for the host pin status and flow control block
module hpsfc_monitor #(
    parameter int unsigned NUM_GPIO = 6
) (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       clk_en,
    input wire hpsfc_pkg::hpsfc_role_t     role,
    input wire hpsfc_pkg::hpsfc_radio_ev_t radio_ev,
    input wire logic                       diag_alt_en,
    input wire logic                       diag_serial_out,
    input wire logic                       flow_ctrl_en,
    input wire logic                       rx_can_accept,
    input wire logic                       tx_permit,
    input wire logic                       activity_indicator,
    input wire logic                       carrier_detect_n,
    input wire logic                       carrier_detect_oe_n,
    input wire logic [NUM_GPIO-1:0]        gpio_in,
    input wire logic [NUM_GPIO-1:0]        gpio_out,
    input wire logic [NUM_GPIO-1:0]        gpio_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import hpsfc_pkg::*;
    // a frozen clock enable holds all state, so nothing is judged then
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n || !clk_en);
    a_base_rx_blink: assert property (
        role == HPSFC_ROLE_BASE && radio_ev.rx_valid && !diag_alt_en |=> activity_indicator)
        else $error("no blink on base receive");
    a_remote_tx_blink: assert property (
        role == HPSFC_ROLE_REMOTE && radio_ev.tx_packet && !diag_alt_en |=> activity_indicator)
        else $error("no blink on remote transmit");
    a_router_blink: assert property (
        role == HPSFC_ROLE_ROUTER && !diag_alt_en && (radio_ev.rx_valid && radio_ev.rx_upstream
        || radio_ev.tx_packet && radio_ev.tx_downstream) |=> activity_indicator)
        else $error("no blink on router traffic");
    a_base_carrier_on: assert property (
        role == HPSFC_ROLE_BASE && radio_ev.rx_valid && !diag_alt_en |=> !carrier_detect_n)
        else $error("carrier not raised by base receive");
    a_sync_carrier_on: assert property (
        role != HPSFC_ROLE_BASE && radio_ev.sync_gained && !diag_alt_en |=> !carrier_detect_n)
        else $error("carrier not raised by sync");
    a_diag_serial_out_path: assert property (
        diag_alt_en [*2] |-> activity_indicator == $past(diag_serial_out))
        else $error("diagnostic output not on activity pin");
    a_diag_serial_in_float: assert property (
        diag_alt_en [*2] |-> carrier_detect_oe_n)
        else $error("carrier pin driven in diagnostic mode");
    a_default_drive: assert property (
        (!diag_alt_en) [*2] |-> !carrier_detect_oe_n)
        else $error("carrier pin not driven by default");
    a_cts_follow: assert property (
        flow_ctrl_en ##1 flow_ctrl_en |-> gpio_out[4] == !$past(rx_can_accept) && !gpio_oe_n[4])
        else $error("clear-to-send does not follow readiness");
    a_rts_stop: assert property (
        (flow_ctrl_en && gpio_in[5]) [*4] |-> !tx_permit)
        else $error("transmit allowed while host withholds");
    c_blink: cover property (!activity_indicator ##1 activity_indicator);
    c_carrier_drop: cover property (!carrier_detect_n ##1 carrier_detect_n);
    c_cts_busy: cover property (flow_ctrl_en && gpio_out[4]);
endmodule // hpsfc_monitor

bind hpsfc_top hpsfc_monitor #(.NUM_GPIO(NUM_GPIO)) u_monitor (.clk, .reset_n, .clk_en, .role, .radio_ev,
    .diag_alt_en, .diag_serial_out, .flow_ctrl_en, .rx_can_accept, .tx_permit, .activity_indicator,
    .carrier_detect_n, .carrier_detect_oe_n, .gpio_in, .gpio_out, .gpio_oe_n);

// file: hpsfc_host_model.sv
// host controller model on the two flow-control pins
module hpsfc_host_model (
    input  wire logic clk,
    input  wire logic cts_n,
    input  wire logic hold_tx,
    input  wire logic want_send,
    output logic      rts_n,
    output logic      sending
);
    timeunit 1ns;
    timeprecision 1ps;
    // permission and sending change only after a clock edge, like a real host
    always_ff @(posedge clk) begin
        rts_n   <= hold_tx;
        sending <= want_send && !cts_n;
    end
endmodule // hpsfc_host_model

// file: host_pin_status_flow_ctrl_tb_top.sv
// self-checking testbench for the host pin status and flow control block
module host_pin_status_flow_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hpsfc_pkg::*;
    localparam int unsigned BLK = 4; // short blink keeps the run brief
    logic            clk = 1'h0, reset_n = 1'h0, rts_n, hold = 1'h0, host_sending, clk_en = 1'h1;
    hpsfc_role_t     role = HPSFC_ROLE_BASE;
    hpsfc_radio_ev_t radio_ev = '0;
    logic            diag_alt_en = 1'h0, diag_serial_out = 1'h0, diag_serial_in, carrier_detect_n_in = 1'h1;
    logic            flow_ctrl_en = 1'h0, rx_can_accept = 1'h0, tx_permit, sleeping = 1'h0;
    logic            activity_indicator, carrier_detect_n, carrier_detect_oe_n, wake_irq;
    hpsfc_pin_cfg_t  awake_cfg [6] = '{default: '0};
    hpsfc_pin_cfg_t  sleep_cfg [6] = '{default: '0};
    logic [5:0]      ext = 6'h3F, pin, gpio_out, gpio_oe_n, gpio_pull_up, gpio_level;
    int              num_errors = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    // a pin shows the device where it drives, else the outside party; the host owns pin 5 only in flow mode
    assign pin = (gpio_oe_n & {flow_ctrl_en ? rts_n : ext[5], ext[4:0]}) | (~gpio_oe_n & gpio_out);
    hpsfc_top #(.BLINK_CYCLES(BLK)) dut (.clk, .reset_n, .clk_en, .role, .radio_ev,
        .reg_timeout_cycles(32'h14), .diag_alt_en, .diag_serial_out, .diag_serial_in, .flow_ctrl_en,
        .rx_can_accept, .tx_permit, .sleeping, .awake_cfg, .sleep_cfg, .activity_indicator,
        .carrier_detect_n_in, .carrier_detect_n, .carrier_detect_oe_n, .gpio_in(pin), .gpio_out,
        .gpio_oe_n, .gpio_pull_up, .gpio_level, .wake_irq);
    hpsfc_host_model host (.clk, .cts_n(gpio_out[4]), .hold_tx(hold), .want_send(flow_ctrl_en),
        .rts_n, .sending(host_sending));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // inputs move 1 ns after an edge, outputs are settled by then
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [6:0] e);
        radio_ev = e;
        cyc(1);
        radio_ev = '0;
        cyc(1); // an idle edge keeps back-to-back pulses apart
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_blink;
        hpsfc_role_t r [4] = '{HPSFC_ROLE_BASE, HPSFC_ROLE_REMOTE, HPSFC_ROLE_ROUTER, HPSFC_ROLE_ROUTER};
        logic [6:0]  hit [4] = '{7'h40, 7'h10, 7'h60, 7'h18};
        logic [6:0]  miss [4] = '{7'h10, 7'h40, 7'h04, 7'h04};
        for (int i = 0; i < 4; i++) begin
            role = r[i];
            cyc(2 * BLK + 4);
            pulse(miss[i]);
            chk(activity_indicator, 8'h0);
            pulse(hit[i]);
            chk(activity_indicator, 8'h1);
        end
    endtask
    // a low clock enable must swallow an event and hold the indicator
    task automatic t_freeze;
        role = HPSFC_ROLE_BASE;
        cyc(2 * BLK + 4);
        clk_en = 1'h0;
        pulse(7'h40);
        chk(activity_indicator, 8'h0);
        clk_en = 1'h1;
        pulse(7'h40);
        chk(activity_indicator, 8'h1);
    endtask
    task automatic t_base_carrier;
        role = HPSFC_ROLE_BASE;
        pulse(7'h40);
        cyc(10);
        chk(carrier_detect_n, 8'h0);
        cyc(14);
        chk(carrier_detect_n, 8'h1);
    endtask
    // a beacon midway restarts the count of silent hops
    task automatic t_hops(input hpsfc_role_t r);
        role = r;
        pulse(7'h04);
        repeat (49) pulse(7'h02);
        pulse(7'h01);
        repeat (49) pulse(7'h02);
        cyc(1);
        chk(carrier_detect_n, 8'h0);
        pulse(7'h02);
        cyc(1);
        chk(carrier_detect_n, 8'h1);
    endtask
    task automatic t_diag;
        diag_alt_en = 1'h1;
        for (int i = 0; i < 4; i++) begin
            diag_serial_out = i[0];
            carrier_detect_n_in = i[1];
            cyc(3);
            chk(activity_indicator, i[0]);
            chk({diag_serial_in, carrier_detect_oe_n}, {i[1], 1'h1});
        end
        diag_alt_en = 1'h0;
        cyc(2);
        chk(carrier_detect_oe_n, 8'h0);
    endtask
    task automatic t_flow;
        flow_ctrl_en = 1'h1;
        for (int i = 1; i >= 0; i--) begin
            rx_can_accept = i[0];
            hold = i[0];
            cyc(4);
            chk({gpio_out[4], gpio_oe_n[4], gpio_oe_n[5]}, {!i[0], 2'h1});
            chk(tx_permit, !i[0]);
            chk(host_sending, i[0]);
        end
        flow_ctrl_en = 1'h0;
    endtask
    // awake as a driven high output, asleep as a pulled-up wake input held low
    task automatic t_gpio(input int p);
        awake_cfg[p] = 4'h9;
        sleep_cfg[p] = 4'h6;
        ext[p] = 1'h0;
        cyc(2);
        chk({gpio_oe_n[p], gpio_out[p]}, 8'h1);
        sleeping = 1'h1;
        cyc(3);
        chk({gpio_oe_n[p], gpio_pull_up[p], gpio_level[p], wake_irq}, 8'hD);
        sleeping = 1'h0;
        awake_cfg[p] = 4'h0;
        sleep_cfg[p] = 4'h0;
        ext[p] = 1'h1;
        cyc(3);
    endtask
    initial begin
        #20us;
        num_errors++;
        wrap_up();
    end
    initial begin
        cyc(4);
        chk({activity_indicator, carrier_detect_n, gpio_oe_n}, 8'h7F);
        reset_n = 1'h1;
        t_blink();
        t_freeze();
        t_base_carrier();
        t_hops(HPSFC_ROLE_ROUTER);
        t_hops(HPSFC_ROLE_REMOTE);
        t_diag();
        t_flow();
        foreach (ext[p]) t_gpio(p);
        wrap_up();
    end
endmodule // host_pin_status_flow_ctrl_tb_top
